// [shared/ext_match_pkg.sv]
// Package with constants and carrier types for the external address match port.
package ext_match_pkg;

  // Byte-time figures; one local byte clock cycle is one byte time.
  localparam int unsigned INHIBIT_DEADLINE_BYTE = 7;   // INFO byte that busy/inhibit must come before.
  localparam int unsigned ED_BUSY_LIMIT         = 2;   // Byte times after ED for busy to drop.
  localparam int unsigned STRIP_DELAY           = 3;   // Byte times from source match to strip.
  localparam int unsigned LEARN_INFO_BYTE       = 4;   // INFO byte that sets the learn point.
  localparam int unsigned LEARN_PIPE_DELAY      = 3;   // Byte times from PHY to system side.
  localparam logic [3:0]  INFO_CNT_RESET        = 4'h0;
  localparam logic [1:0]  ED_CNT_RESET          = 2'h0;
  localparam logic [2:0]  STRIP_PIPE_RESET      = 3'h0;
  localparam logic [2:0]  LEARN_PIPE_RESET      = 3'h0;

  // Frame progress states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FRAME = 4'h2,
    ST_TAIL  = 4'h4,
    ST_DONE  = 4'h8
  } frame_state_t;

  // Comparison tracking, one-hot.
  typedef enum logic [2:0] {
    CMP_WAIT = 3'h1,
    CMP_BUSY = 3'h2,
    CMP_OVER = 3'h4
  } cmp_state_t;

  // Inputs from the external address recognition logic.
  typedef struct packed {
    logic compareBusy;
    logic copyRequest;
    logic destMatch;
    logic srcMatch;
    logic matchInhibit;
  } ext_in_t;

  // Frame timing marks from the ring engine.
  typedef struct packed {
    logic frameStart;     // Start delimiter seen.
    logic infoByte;       // One INFO byte accepted at the PHY side.
    logic preEnd;         // One byte time before the ending delimiter.
    logic endDelim;       // Ending delimiter received.
    logic longAddr;       // Frame carries long addresses.
    logic ownSource;      // Internal source match for this station.
    logic satSent;        // A transparent-source frame was transmitted.
    logic ownVoidBack;    // Own void frame has returned.
  } ring_evt_t;

  // Decisions handed back to the ring and system sides.
  typedef struct packed {
    logic copyFrame;
    logic addrRecognized;
    logic stripStart;
    logic learn;
    logic learnValid;
    logic matchFlag;
    logic decisionDone;
  } decide_t;

  typedef struct packed {
    frame_state_t fState;
    cmp_state_t   cState;
    logic         busyIdle;     // Idle level of busy, caught at frame start.
    logic         busyPrev;
    logic [3:0]   infoCnt;
    logic [1:0]   edCnt;
    logic         extValid;
    logic         copyReq;
    logic         srcHit;
    logic         stripFired;   // Strip timer already started in this frame.
    logic         destHit;
    logic         inhibitArm;
    logic         satHold;
    logic [2:0]   stripPipe;
    logic [2:0]   learnPipe;
    decide_t      out;
  } state_t;

endpackage : ext_match_pkg

// [testbench/ext_matcher_model.sv]
// Behavioural model of the external address recognition logic.
`timescale 1ns/1ps
`default_nettype none
module ext_matcher_model (
  input  wire logic                   clk,     // Byte clock.
  input  wire logic                   go,      // Start one comparison.
  input  wire logic [4:0]             busyLen, // Busy length in byte times.
  input  wire logic                   idleLvl, // Idle level of busy.
  input  wire logic [3:0]             res,     // Copy, dest, source, inhibit results.
  output var  ext_match_pkg::ext_in_t extIn    // Lines toward the port.
);
  logic [4:0] left_r;

  initial left_r = 5'h00;

  always @(posedge clk) begin
    if (go) begin
      left_r <= busyLen;
    end else if (left_r != 5'h00) begin
      left_r <= left_r - 5'h01;
    end
  end

  // The copy result is unsettled, shown inverted, until the comparison ends.
  always_comb begin
    extIn.compareBusy  = (left_r != 5'h00) ? ~idleLvl : idleLvl;
    extIn.copyRequest  = res[3] ^ (left_r != 5'h00);
    extIn.destMatch    = res[2];
    extIn.srcMatch     = res[1];
    extIn.matchInhibit = res[0];
  end
endmodule : ext_matcher_model
`default_nettype wire

// [testbench/tb_external_address_match_port.sv]
// Self-checking bench for the external address match port.
`timescale 1ns/1ps
`default_nettype none
module tb_external_address_match_port;
  logic                     clk;
  logic                     srst;
  logic                     go;
  logic [4:0]               busyLen;
  logic                     idleLvl;
  logic [3:0]               res;
  logic                     internalMatch;
  logic                     inhibitPinEnable;
  logic                     copyRes;
  logic                     lrn;
  logic                     srcPrev;
  ext_match_pkg::ext_in_t   extIn;
  ext_match_pkg::ring_evt_t ringEvt;
  ext_match_pkg::decide_t   decide;
  int                       err_total;
  int                       tests_run;
  int                       cyc;
  int                       nInfo;
  int                       tI4;
  int                       tLv;
  int                       tSrc;
  int                       tStrip;

  external_address_match_port DUT (
    .clk(clk), .srst(srst), .ce(1'b1), .extIn(extIn), .ringEvt(ringEvt),
    .internalMatch(internalMatch), .copyResource(copyRes),
    .inhibitPinEnable(inhibitPinEnable), .decide(decide));

  ext_matcher_model partner (
    .clk(clk), .go(go), .busyLen(busyLen), .idleLvl(idleLvl), .res(res), .extIn(extIn));

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One frame; e holds copy, recognized, flag and learn, m selects which are judged.
  task automatic run_frame(input logic [4:0] goAt, input logic [4:0] len,
                           input logic [3:0] r, input logic [3:0] e, input logic [3:0] m);
    logic [4:0] i;
    logic [3:0] got;
    for (i = 5'h00; i < 5'h0E; i++) begin
      @(posedge clk);
      ringEvt.frameStart <= (i == 5'h00);
      ringEvt.infoByte   <= (i >= 5'h01) && (i <= 5'h08);
      ringEvt.preEnd     <= (i == 5'h0A);
      ringEvt.endDelim   <= (i == 5'h0C);
      go                 <= (i == goAt);
      busyLen            <= len;
      if (i == goAt) begin
        res <= r;
      end
    end
    for (i = 5'h00; i < 5'h14 && decide.decisionDone !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    got = {decide.copyFrame, decide.addrRecognized, decide.matchFlag, lrn};
    check({4'h0, got & m}, {4'h0, e & m}, "decisions");
    check({7'h00, decide.decisionDone}, 8'h01, "decision done");
    if (m[0]) check(8'(tLv - tI4), 8'h04, "learn timing");
    if (r[1]) check(8'(tStrip - tSrc), 8'h04, "strip timing");
    repeat (16) @(posedge clk);
    res <= 4'h0;
  endtask : run_frame

  task automatic t_polarity;
    run_frame(5'h02, 5'h04, 4'h8, 4'h9, 4'hF);
    @(posedge clk);
    idleLvl <= 1'b1;
    run_frame(5'h02, 5'h04, 4'h8, 4'h9, 4'hF);
    @(posedge clk);
    idleLvl <= 1'b0;
  endtask : t_polarity

  task automatic t_refusals;
    run_frame(5'h08, 5'h02, 4'h8, 4'h0, 4'h8);
    run_frame(5'h02, 5'h18, 4'hC, 4'h0, 4'h8);
    copyRes <= 1'b0;
    run_frame(5'h02, 5'h04, 4'h8, 4'h0, 4'h8);
    copyRes <= 1'b1;
  endtask : t_refusals

  task automatic t_dest_src;
    ringEvt.longAddr <= 1'b0;
    run_frame(5'h02, 5'h04, 4'h6, 4'hC, 4'hD);
    ringEvt.longAddr <= 1'b1;
  endtask : t_dest_src

  task automatic t_inhibit;
    internalMatch    <= 1'b1;
    inhibitPinEnable <= 1'b1;
    run_frame(5'h02, 5'h04, 4'h1, 4'h0, 4'h2);
    inhibitPinEnable <= 1'b0;
    run_frame(5'h02, 5'h04, 4'h1, 4'h2, 4'h2);
    internalMatch    <= 1'b0;
  endtask : t_inhibit

  task automatic t_sat_hold;
    @(posedge clk);
    ringEvt.satSent <= 1'b1;
    @(posedge clk);
    ringEvt.satSent <= 1'b0;
    run_frame(5'h1F, 5'h01, 4'h0, 4'h0, 4'h1);
    ringEvt.ownVoidBack <= 1'b1;
    @(posedge clk);
    ringEvt.ownVoidBack <= 1'b0;
    run_frame(5'h1F, 5'h01, 4'h0, 4'h1, 4'h1);
  endtask : t_sat_hold

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Event times in clock counts, for the latency checks.
  always @(posedge clk) begin
    cyc     <= cyc + 1;
    srcPrev <= extIn.srcMatch;
    if (ringEvt.frameStart) nInfo <= 0;
    if (ringEvt.infoByte) nInfo <= nInfo + 1;
    if (ringEvt.infoByte && nInfo == 3) tI4 <= cyc;
    if (decide.learnValid === 1'b1) tLv <= cyc;
    if (decide.learnValid === 1'b1) lrn <= decide.learn;
    if (extIn.srcMatch && !srcPrev) tSrc <= cyc;
    if (decide.stripStart === 1'b1) tStrip <= cyc;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    {srst, go, busyLen, idleLvl, res, internalMatch, inhibitPinEnable} = '0;
    {err_total, tests_run, cyc, nInfo, tI4, tLv, tSrc, tStrip} = '0;
    {lrn, srcPrev} = 2'h0;
    ringEvt = '0;
    ringEvt.longAddr = 1'b1;
    copyRes = 1'b1;
    srst = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_polarity();
    t_refusals();
    t_dest_src();
    t_inhibit();
    t_sat_hold();
    final_report();
  end
endmodule : tb_external_address_match_port
`default_nettype wire

// [verilog/external_address_match_port.sv]
// External address match port: samples external compare results per frame.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Busy rises at compare start, falls at end; sample copy and source match after fall.
// - Frame is not copied if busy still active two byte times after ED.
// - Busy may be a positive or a negative pulse; both are detected.
// - Busy affects frame handling even without external copy mode.
// - Sampled copy request copies the frame when resources permit.
// - Destination match sampled one byte before ED, feeds address-recognized indicator.
// - Source match starts stripping three byte times after its assertion.
// - Learn asserted for long-address frames not sourced by this station.
// - Learn held false from first transparent frame until own void frame returns.
// - Learn valid three byte times after the fourth INFO byte arrives.
// - Inhibit before INFO byte seven blocks internal match flag for that frame.
// - Inhibit is ignored unless the inhibit pin enable bit is set.
module external_address_match_port (
  input  wire logic                       clk,           // Local byte clock.
  input  wire logic                       srst,          // Synchronous reset, active high.
  input  wire logic                       ce,            // Clock enable.
  input  wire ext_match_pkg::ext_in_t     extIn,         // External match inputs.
  input  wire ext_match_pkg::ring_evt_t   ringEvt,       // Ring engine frame marks.
  input  wire logic                       internalMatch, // Internal address match.
  input  wire logic                       copyResource,  // Receive resources available.
  input  wire logic                       inhibitPinEnable, // Inhibit enable mode bit.
  output var  ext_match_pkg::decide_t     decide         // Frame decisions.
);

  ext_match_pkg::state_t s_r;
  ext_match_pkg::state_t s_nxt;

  logic busyAct;
  logic busyActPrev;

  // Busy is judged against its idle level, so either pulse polarity works.
  function automatic logic active(input logic lvl, input logic idleLvl);
    active = lvl ^ idleLvl;
  endfunction : active

  assign busyAct     = active(extIn.compareBusy, s_r.busyIdle);
  assign busyActPrev = active(s_r.busyPrev, s_r.busyIdle);

  always_comb begin
    s_nxt = s_r;
    s_nxt.busyPrev = extIn.compareBusy;
    s_nxt.out.stripStart = s_r.stripPipe[ext_match_pkg::STRIP_DELAY-1];
    s_nxt.stripPipe = {s_r.stripPipe[1:0], 1'b0};
    s_nxt.out.learnValid = s_r.learnPipe[ext_match_pkg::LEARN_PIPE_DELAY-1];
    s_nxt.learnPipe = {s_r.learnPipe[1:0], 1'b0};
    s_nxt.out.decisionDone = 1'b0;
    if (ringEvt.satSent) begin
      s_nxt.satHold = 1'b1;
    end else if (ringEvt.ownVoidBack) begin
      s_nxt.satHold = 1'b0;
    end
    case (s_r.fState)
      ext_match_pkg::ST_IDLE: begin
        if (ringEvt.frameStart) begin
          s_nxt.fState     = ext_match_pkg::ST_FRAME;
          s_nxt.cState     = ext_match_pkg::CMP_WAIT;
          s_nxt.busyIdle   = extIn.compareBusy;
          s_nxt.infoCnt    = ext_match_pkg::INFO_CNT_RESET;
          s_nxt.edCnt      = ext_match_pkg::ED_CNT_RESET;
          s_nxt.extValid   = 1'b0;
          s_nxt.copyReq    = 1'b0;
          s_nxt.srcHit     = 1'b0;
          s_nxt.stripFired = 1'b0;
          s_nxt.destHit    = 1'b0;
          s_nxt.inhibitArm = 1'b0;
          s_nxt.out.copyFrame      = 1'b0;
          s_nxt.out.addrRecognized = 1'b0;
          s_nxt.out.learn          = 1'b0;
          s_nxt.out.matchFlag      = 1'b0;
        end
      end
      ext_match_pkg::ST_FRAME, ext_match_pkg::ST_TAIL: begin
        if (ringEvt.infoByte && s_r.infoCnt != 4'hF) begin
          s_nxt.infoCnt = s_r.infoCnt + 4'h1;
        end
        // The count lags the INFO byte being accepted by one; below six still takes the sixth, not the seventh.
        if (s_r.infoCnt < 4'(ext_match_pkg::INHIBIT_DEADLINE_BYTE - 1)) begin
          if (s_r.cState == ext_match_pkg::CMP_WAIT && busyAct) begin
            s_nxt.cState = ext_match_pkg::CMP_BUSY;
          end
          if (extIn.matchInhibit && inhibitPinEnable) begin
            s_nxt.inhibitArm = 1'b1;
          end
        end
        if (s_r.cState == ext_match_pkg::CMP_BUSY && !busyAct && busyActPrev) begin
          s_nxt.cState   = ext_match_pkg::CMP_OVER;
          s_nxt.extValid = 1'b1;
          s_nxt.copyReq  = extIn.copyRequest;
          s_nxt.srcHit   = extIn.srcMatch;
        end
        // Source match is a level; only its first appearance in a frame starts the strip.
        if (extIn.srcMatch && !s_r.stripFired) begin
          s_nxt.stripPipe[0] = 1'b1;
          s_nxt.stripFired   = 1'b1;
        end
        if (ringEvt.infoByte && s_r.infoCnt == 4'(ext_match_pkg::LEARN_INFO_BYTE - 1)) begin
          s_nxt.learnPipe[0] = 1'b1;
          s_nxt.out.learn = ringEvt.longAddr && !ringEvt.ownSource
                            && !extIn.srcMatch && !s_r.satHold;
        end
        if (ringEvt.preEnd) begin
          s_nxt.destHit = extIn.destMatch;
          s_nxt.out.addrRecognized = extIn.destMatch | internalMatch;
        end
        if (ringEvt.endDelim) begin
          s_nxt.fState = ext_match_pkg::ST_TAIL;
          s_nxt.out.matchFlag = internalMatch && !s_r.inhibitArm;
        end
        if (s_r.fState == ext_match_pkg::ST_TAIL) begin
          s_nxt.edCnt = s_r.edCnt + 2'h1;
          if (s_r.edCnt == 2'(ext_match_pkg::ED_BUSY_LIMIT - 1)) begin
            s_nxt.fState = ext_match_pkg::ST_DONE;
            // A comparison still running now forbids the copy.
            s_nxt.out.copyFrame = (s_nxt.cState != ext_match_pkg::CMP_BUSY) && copyResource
                                  && ((s_nxt.extValid && s_nxt.copyReq) || internalMatch
                                  || s_r.destHit);
          end
        end
      end
      ext_match_pkg::ST_DONE: begin
        s_nxt.out.decisionDone = 1'b1;
        s_nxt.fState = ext_match_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.fState = ext_match_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '{fState: ext_match_pkg::ST_IDLE, cState: ext_match_pkg::CMP_WAIT,
               infoCnt: ext_match_pkg::INFO_CNT_RESET, edCnt: ext_match_pkg::ED_CNT_RESET,
               stripPipe: ext_match_pkg::STRIP_PIPE_RESET,
               learnPipe: ext_match_pkg::LEARN_PIPE_RESET, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign decide = s_r.out;

  sequence srcRise;
    ce && extIn.srcMatch && !s_r.stripFired && s_r.fState == ext_match_pkg::ST_FRAME;
  endsequence

  a_strip_delay: assert property (@(posedge clk) disable iff (srst)
    srcRise ##1 ce[*3] |=> decide.stripStart)
    else $error("Strip did not start three byte times after source match.");

  a_learn_point: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.learnPipe[0]) ##1 ce[*2] |=> decide.learnValid)
    else $error("Learn valid missing at the info received point.");

  a_learn_sat: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.satHold && s_r.learnPipe[0]) |-> !decide.learn)
    else $error("Learn asserted during transparent source hold.");

  a_inhibit_gate: assert property (@(posedge clk) disable iff (srst)
    (ce && !inhibitPinEnable && s_r.fState == ext_match_pkg::ST_FRAME && !s_r.inhibitArm)
      |=> !s_r.inhibitArm)
    else $error("Inhibit armed while the inhibit pin is disabled.");

  a_inhibit_flag: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.inhibitArm && ringEvt.endDelim) |=> !decide.matchFlag)
    else $error("Internal match flag passed despite inhibit.");

  a_busy_nocopy: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_DONE && s_r.cState == ext_match_pkg::CMP_BUSY)
      |-> !decide.copyFrame)
    else $error("Frame copied while comparison still busy.");

  a_copy_request: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_TAIL && s_r.edCnt == 2'h1 && s_r.extValid
      && s_r.copyReq && copyResource && s_r.cState != ext_match_pkg::CMP_BUSY)
      |=> decide.copyFrame)
    else $error("Requested copy was not taken.");

  a_sample_hold: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.cState == ext_match_pkg::CMP_OVER && s_r.fState != ext_match_pkg::ST_IDLE)
      |=> $stable(s_r.copyReq) || !ce)
    else $error("Sampled copy request changed within the frame.");

  a_dest_sample: assert property (@(posedge clk) disable iff (srst)
    (ce && ringEvt.preEnd && extIn.destMatch && s_r.fState == ext_match_pkg::ST_FRAME)
      |=> decide.addrRecognized)
    else $error("Destination match not reflected in address recognized.");

  // Completion of a comparison: busy was active and is back at its idle level.
  sequence busyDone;
    ce && s_r.cState == ext_match_pkg::CMP_BUSY && !busyAct && busyActPrev
      && (s_r.fState == ext_match_pkg::ST_FRAME || s_r.fState == ext_match_pkg::ST_TAIL);
  endsequence

  a_busy_sample: assert property (@(posedge clk) disable iff (srst)
    busyDone |=> s_r.extValid && s_r.copyReq == $past(extIn.copyRequest)
      && s_r.srcHit == $past(extIn.srcMatch))
    else $error("Copy and source results not taken when busy ended.");

  a_busy_start: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_FRAME && s_r.cState == ext_match_pkg::CMP_WAIT
      && busyAct && s_r.infoCnt < 4'(ext_match_pkg::INHIBIT_DEADLINE_BYTE - 1))
      |=> s_r.cState == ext_match_pkg::CMP_BUSY)
    else $error("Active busy level not taken as a comparison start.");

  a_busy_late: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_FRAME && s_r.cState == ext_match_pkg::CMP_WAIT
      && s_r.infoCnt >= 4'(ext_match_pkg::INHIBIT_DEADLINE_BYTE - 1))
      |=> s_r.cState == ext_match_pkg::CMP_WAIT)
    else $error("Late busy taken as an external comparison.");

  a_strip_once: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.stripFired && s_r.fState != ext_match_pkg::ST_IDLE) |=> !s_r.stripPipe[0])
    else $error("Strip timer restarted within one frame.");

  a_learn_long: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_FRAME && ringEvt.infoByte && !ringEvt.longAddr
      && s_r.infoCnt == 4'(ext_match_pkg::LEARN_INFO_BYTE - 1)) |=> !decide.learn)
    else $error("Learn asserted for a short address frame.");

  a_void_clear: assert property (@(posedge clk) disable iff (srst)
    (ce && ringEvt.ownVoidBack && !ringEvt.satSent) |=> !s_r.satHold)
    else $error("Transparent source hold kept after own void frame.");

  a_flag_pass: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_FRAME && ringEvt.endDelim && internalMatch
      && !s_r.inhibitArm) |=> decide.matchFlag)
    else $error("Internal match flag lost without inhibit.");

  a_done_pulse: assert property (@(posedge clk) disable iff (srst)
    (ce && s_r.fState == ext_match_pkg::ST_DONE) |=> decide.decisionDone)
    else $error("Decision done pulse missing.");

endmodule : external_address_match_port
`default_nettype wire
